// file: shared/intc_pkg.sv
// Shared constants for the interrupt and low-power controller.
// Assumes a 32-bit APB master and a 100 MHz clock.
package intc_pkg;
	localparam int NSRC = 12;
	localparam int STACK_DEPTH = 12;
	// Source index, 0 is highest priority after reset.
	localparam int SRC_PWD = 0;
	localparam int SRC_SEL = 1;
	localparam int SRC_LVB = 2;
	localparam int SRC_LVA = 3;
	localparam int SRC_SATX = 4;
	localparam int SRC_SARX = 5;
	localparam int SRC_EDGE = 6;
	localparam int SRC_DMA = 7;
	localparam int SRC_SBTX = 8;
	localparam int SRC_SBRX = 9;
	localparam int SRC_TMR = 10;
	localparam int SRC_SW = 11;
	localparam logic [13:0] VEC_RESET = 14'h0000;
	localparam logic [13:0] VEC_SW = 14'h0030;
	localparam logic [13:0] VEC_TABLE [NSRC] = '{14'h002C, 14'h0004, 14'h0008,
		14'h000C, 14'h0010, 14'h0014, 14'h0018, 14'h001C, 14'h0020, 14'h0024,
		14'h0028, VEC_SW};
	// Register byte offsets.
	localparam logic [7:0] OFF_MASK = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_FORCE = 8'h08;
	localparam logic [7:0] OFF_CMD = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_PEND = 8'h14;
	// Control register fields.
	localparam int CTRL_SEL_EDGE = 0;
	localparam int CTRL_ALTA_EDGE = 1;
	localparam int CTRL_ALTB_EDGE = 2;
	localparam int CTRL_NEST = 3;
	localparam int CTRL_XTAL_OFF = 4;
	localparam int CTRL_CONTEXT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [11:0] MASK_RESET = 12'h000;
	// Command register bits, self-clearing.
	localparam int CMD_ENA = 0;
	localparam int CMD_DIS = 1;
	localparam int CMD_IDLE = 2;
	localparam int CMD_RTI = 3;
	localparam int CMD_PWD_FORCE = 4;
	localparam int CMD_DIV_LO = 8;
	// Wake timing in input-clock cycles; input clock is half the cycle rate.
	localparam int WAKE_FAST_IN = 400;
	localparam int WAKE_XTAL_IN = 4096;
	localparam int CYC_PER_IN = 2;
	localparam int WAKE_FAST_CYC = WAKE_FAST_IN * CYC_PER_IN;
	localparam int WAKE_XTAL_CYC = WAKE_XTAL_IN * CYC_PER_IN;
endpackage

// file: shared/stk_if.sv
// Push and pop port of the status stack.
// Assumes one master and one stack on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface stk_if;
	logic push;
	logic pop;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic full;
	logic empty;
	modport master(output push, output pop, output wdata, input rdata, input full, input empty);
	modport stack(input push, input pop, input wdata, output rdata, output full, output empty);
endinterface
`default_nettype wire

// file: design/status_stack.sv
// Hardware stack of saved status words.
// Assumes the master never pushes when full nor pops when empty.
`timescale 1ns/1ns
`default_nettype none
module status_stack #(
	parameter int DEPTH = 12
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	stk_if.stack s
);
	logic [31:0] mem_ff [DEPTH];
	logic [3:0] ptr_ff;
	wire do_push = s.push && !s.full;
	wire do_pop = s.pop && !s.empty;
	assign s.full = (ptr_ff == 4'(DEPTH));
	assign s.empty = (ptr_ff == 4'h0);
	assign s.rdata = s.empty ? 32'h00000000 : mem_ff[ptr_ff - 4'h1];
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ptr_ff <= 4'h0;
		end else if (do_push) begin
			ptr_ff <= ptr_ff + 4'h1;
		end else if (do_pop) begin
			ptr_ff <= ptr_ff - 4'h1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem_ff[ptr_ff[3:0]] <= s.wdata;
		end
	end
endmodule
`default_nettype wire

// file: design/intc_lowpower.sv
// Interrupt controller and low-power control for a DSP sequencer.
// Assumes pins are asynchronous, APB on clk_in, sequencer takes vectors.
// What this block does
// - Twelve sources plus reset, fixed priority.
// - Pin vectors 0004, 0008, 000C.
// - Serial vectors 0010, 0014, 0020, 0024.
// - Reset 0000, DMA 001C, timer 0028.
// - Pending AND mask, highest wins.
// - Power-down and reset are nonmaskable.
// - Control bit selects nesting or sequential.
// - Mask write blocks interrupts one cycle.
// - Three pins selectable edge or level.
// - Edge pin forceable; level pins pure level.
// - Force/clear register is write-only.
// - Twelve-deep stack saves status on entry.
// - Global enable/disable gates all servicing.
// - Global enable set after reset.
// - Power-down wake in 400 input cycles.
// - Oscillator off means 4096-cycle wait.
// - Power-down from pin or force, edge.
// - Acknowledge in power-down; reset ends it.
// - Context bit selects resume or clear.
// - Idle waits for unmasked interrupt.
// - Divided idle slows clock 16 to 128.
// - Divided idle wake waits up to n.
`timescale 1ns/1ns
`default_nettype none
module intc_lowpower
	import intc_pkg::*;
#(
	parameter int WAKE_XTAL = WAKE_XTAL_CYC,
	parameter int WAKE_FAST = WAKE_FAST_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic ext_selectable_int_n_in,
	input wire logic ext_level_int_a_n_in,
	input wire logic ext_level_int_b_n_in,
	input wire logic ext_edge_int_n_in,
	input wire logic serial_alt_int_a_n_in,
	input wire logic serial_alt_int_b_n_in,
	input wire logic powerdown_request_pin_n_in,
	input wire logic serial_alt_mode_in,
	input wire logic [5:0] internal_int_in,
	input wire logic [31:0] status_in,
	output logic int_take_out,
	output logic [13:0] vector_out,
	output logic [31:0] status_restore_out,
	output logic context_clear_out,
	output logic run_out,
	output logic cycle_clock_output_out,
	output logic powerdown_ack_out
);
	typedef enum {ST_RUN, ST_IDLE, ST_WAKEDIV, ST_PWD, ST_WAKEUP} pstate_t;
	// Two-flop synchronisers for the seven pins, all active low.
	logic [6:0] pin_s1_ff;
	logic [6:0] pin_s2_ff;
	logic [6:0] pin_s3_ff;
	wire [6:0] pin_raw = {powerdown_request_pin_n_in, serial_alt_int_b_n_in,
		serial_alt_int_a_n_in, ext_edge_int_n_in, ext_level_int_b_n_in,
		ext_level_int_a_n_in, ext_selectable_int_n_in};
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_s1_ff <= 7'h7F;
			pin_s2_ff <= 7'h7F;
			pin_s3_ff <= 7'h7F;
		end else begin
			pin_s1_ff <= pin_raw;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end
	wire [6:0] pin_lvl = ~pin_s2_ff;
	wire [6:0] pin_fall = ~pin_s2_ff & pin_s3_ff;
	// Registers.
	logic [11:0] mask_ff;
	logic [5:0] ctrl_ff;
	logic gie_ff;
	logic mask_block_ff;
	logic [11:0] latch_ff;
	logic [11:0] active_ff;
	pstate_t state_ff;
	logic [13:0] wait_ff;
	logic [7:0] div_ff;
	logic [7:0] divcnt_ff;
	logic ckout_ff;
	logic take_ff;
	logic [13:0] vec_ff;
	logic [31:0] restore_ff;
	logic ctxclr_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	stk_if stk();
	status_stack #(.DEPTH(STACK_DEPTH)) u_stack (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.s(stk)
	);
	// APB decode; single-cycle access phase.
	wire apb_acc = psel_in && penable_in;
	wire apb_wr = apb_acc && pwrite_in;
	wire hit_mask = (paddr_in == OFF_MASK);
	wire hit_ctrl = (paddr_in == OFF_CTRL);
	wire hit_force = (paddr_in == OFF_FORCE);
	wire hit_cmd = (paddr_in == OFF_CMD);
	wire hit_stat = (paddr_in == OFF_STATUS);
	wire hit_pend = (paddr_in == OFF_PEND);
	wire hit_any = hit_mask | hit_ctrl | hit_force | hit_cmd | hit_stat | hit_pend;
	wire wr_mask = apb_wr && hit_mask;
	wire wr_force = apb_wr && hit_force;
	wire wr_cmd = apb_wr && hit_cmd;
	wire cmd_ena = wr_cmd && pwdata_in[CMD_ENA];
	wire cmd_dis = wr_cmd && pwdata_in[CMD_DIS];
	wire cmd_idle = wr_cmd && pwdata_in[CMD_IDLE];
	wire cmd_rti = wr_cmd && pwdata_in[CMD_RTI];
	wire cmd_pwd = wr_cmd && pwdata_in[CMD_PWD_FORCE];
	wire [3:0] cmd_div = pwdata_in[CMD_DIV_LO +: 4];
	wire [11:0] frc_set = wr_force ? pwdata_in[11:0] : 12'h000;
	wire [11:0] frc_clr = wr_force ? pwdata_in[27:16] : 12'h000;
	// The two level-only pins cannot be forced; every other source can.
	wire [11:0] frc_ok = ~((12'h001 << SRC_LVA) | (12'h001 << SRC_LVB));
	// Raw request per source; edge-mode sources are latched, level ones are live.
	wire alt_a = serial_alt_mode_in;
	wire [11:0] edge_mode;
	wire [11:0] edge_ev;
	wire [11:0] lvl_req;
	assign edge_mode = {
		1'b1,
		1'b1,
		alt_a & ctrl_ff[CTRL_ALTA_EDGE],
		alt_a & ctrl_ff[CTRL_ALTB_EDGE],
		1'b1,
		1'b1,
		1'b1,
		1'b1,
		1'b0,
		1'b0,
		ctrl_ff[CTRL_SEL_EDGE],
		1'b1
	};
	assign edge_ev = edge_mode & {
		1'b0,
		internal_int_in[5],
		alt_a & pin_fall[4],
		alt_a & pin_fall[5],
		internal_int_in[2],
		pin_fall[3],
		internal_int_in[3],
		internal_int_in[4],
		1'b0,
		1'b0,
		pin_fall[0],
		pin_fall[6]
	};
	assign lvl_req = ~edge_mode & {
		1'b0,
		1'b0,
		alt_a ? pin_lvl[4] : internal_int_in[0],
		alt_a ? pin_lvl[5] : internal_int_in[1],
		1'b0,
		1'b0,
		1'b0,
		1'b0,
		pin_lvl[1],
		pin_lvl[2],
		pin_lvl[0],
		1'b0
	};
	wire [11:0] pending = latch_ff | lvl_req;
	wire [11:0] eff_mask = mask_ff | 12'h001;
	wire [11:0] unmasked = pending & eff_mask;
	// Fixed priority, index 0 highest.
	logic [3:0] win_idx;
	logic win_vld;
	always_comb begin
		win_idx = 4'h0;
		win_vld = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (unmasked[i]) begin
				win_idx = 4'(i);
				win_vld = 1'b1;
			end
		end
	end
	// Nesting admits only sources above the highest active one; when index 0 is active with others, the next active one sets the limit.
	logic [11:0] above_active;
	always_comb begin
		above_active = 12'h000;
		for (int i = 0; i < NSRC; i++) begin
			if (active_ff[i] && above_active == 12'h000) begin
				above_active = 12'((13'h0001 << i) - 13'h0001);
			end
		end
	end
	wire any_active = |active_ff;
	wire nest_ok = !any_active || (ctrl_ff[CTRL_NEST] && above_active[win_idx]);
	wire can_take = win_vld && gie_ff && !mask_block_ff && nest_ok && !stk.full;
	wire run_state = (state_ff == ST_RUN);
	wire take = can_take && run_state && !cmd_rti;
	wire wake_ev = win_vld && gie_ff && !mask_block_ff;
	wire [11:0] win_onehot = take ? 12'(13'h0001 << win_idx) : 12'h000;
	logic [11:0] rti_clr;
	always_comb begin
		rti_clr = 12'h000;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (active_ff[i]) begin
				rti_clr = 12'(13'h0001 << i);
			end
		end
	end
	assign stk.push = take;
	assign stk.pop = cmd_rti && !stk.empty;
	assign stk.wdata = status_in;
	// Set wins over clear: hardware edge and software force override clear.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			latch_ff <= 12'h000;
			active_ff <= 12'h000;
		end else begin
			latch_ff <= (latch_ff & ~frc_clr & ~win_onehot) | edge_ev
				| (frc_set & frc_ok);
			active_ff <= (active_ff & ~(stk.pop ? rti_clr : 12'h000)) | win_onehot;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_ff <= MASK_RESET;
			ctrl_ff <= CTRL_RESET;
			gie_ff <= 1'b1;
			mask_block_ff <= 1'b0;
		end else begin
			if (wr_mask) begin
				mask_ff <= pwdata_in[11:0];
			end
			if (apb_wr && hit_ctrl) begin
				ctrl_ff <= pwdata_in[5:0];
			end
			if (cmd_ena) begin
				gie_ff <= 1'b1;
			end else if (cmd_dis) begin
				gie_ff <= 1'b0;
			end
			mask_block_ff <= wr_mask;
		end
	end
	// Low-power sequencer.
	wire [7:0] div_sel = (cmd_div == 4'h1) ? 8'd16 : (cmd_div == 4'h2) ? 8'd32 :
		(cmd_div == 4'h3) ? 8'd64 : (cmd_div == 4'h4) ? 8'd128 : 8'd1;
	wire pwd_go = cmd_pwd && active_ff[SRC_PWD];
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff <= ST_RUN;
			wait_ff <= 14'h0000;
			div_ff <= 8'd1;
			divcnt_ff <= 8'h00;
			ckout_ff <= 1'b0;
			ctxclr_ff <= 1'b0;
		end else begin
			divcnt_ff <= (divcnt_ff + 8'h01 >= div_ff) ? 8'h00 : divcnt_ff + 8'h01;
			if (divcnt_ff == 8'h00) begin
				ckout_ff <= !ckout_ff;
			end
			case (state_ff)
				ST_RUN: begin
					ctxclr_ff <= 1'b0;
					if (pwd_go) begin
						state_ff <= ST_PWD;
					end else if (cmd_idle) begin
						state_ff <= ST_IDLE;
						div_ff <= div_sel;
					end
				end
				ST_IDLE: begin
					if (wake_ev) begin
						state_ff <= ST_WAKEDIV;
						wait_ff <= 14'(div_ff - 8'h01) - 14'(divcnt_ff);
					end
				end
				ST_WAKEDIV: begin
					if (wait_ff == 14'h0000) begin
						state_ff <= ST_RUN;
						div_ff <= 8'd1;
					end else begin
						wait_ff <= wait_ff - 14'h0001;
					end
				end
				ST_PWD: begin
					if (pin_fall[6] || wr_force && frc_set[SRC_PWD]) begin
						state_ff <= ST_WAKEUP;
						wait_ff <= ctrl_ff[CTRL_XTAL_OFF] ? 14'(WAKE_XTAL - 1) : 14'(WAKE_FAST - 1);
					end
				end
				ST_WAKEUP: begin
					if (wait_ff == 14'h0000) begin
						state_ff <= ST_RUN;
						ctxclr_ff <= ctrl_ff[CTRL_CONTEXT];
					end else begin
						wait_ff <= wait_ff - 14'h0001;
					end
				end
				default: state_ff <= ST_RUN;
			endcase
		end
	end
	// Sequencer outputs.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			take_ff <= 1'b0;
			vec_ff <= VEC_RESET;
			restore_ff <= 32'h00000000;
		end else begin
			take_ff <= take;
			if (take) begin
				vec_ff <= VEC_TABLE[win_idx];
			end
			if (stk.pop) begin
				restore_ff <= stk.rdata;
			end
		end
	end
	// APB read data; force/clear reads zero.
	wire [31:0] rd_mux = hit_mask ? {20'h00000, mask_ff} :
		hit_ctrl ? {26'h0000000, ctrl_ff} :
		hit_stat ? {16'h0000, 4'(state_ff), 3'h0, gie_ff, div_ff} :
		hit_pend ? {4'h0, active_ff, 4'h0, pending} : 32'h00000000;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= (psel_in && !penable_in && !pwrite_in) ? rd_mux : prdata_ff;
			pslverr_ff <= psel_in && !penable_in && !hit_any;
		end
	end
	assign prdata_out = prdata_ff;
	assign pready_out = 1'b1;
	assign pslverr_out = apb_acc && pslverr_ff;
	assign int_take_out = take_ff;
	assign vector_out = vec_ff;
	assign status_restore_out = restore_ff;
	assign context_clear_out = ctxclr_ff;
	assign run_out = run_state;
	assign cycle_clock_output_out = ckout_ff;
	assign powerdown_ack_out = (state_ff == ST_PWD);
endmodule
`default_nettype wire

// file: tb/intc_assertions.sv
// Port checks for the interrupt and low-power controller.
// Assumes it is bound to intc_lowpower and sees one clock domain.
`timescale 1ns/1ns
`default_nettype none
module intc_assertions
	import intc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic int_take_out,
	input wire logic [13:0] vector_out,
	input wire logic run_out,
	input wire logic powerdown_ack_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	wire acc = psel_in && penable_in;
	wire hole = !(paddr_in inside {OFF_MASK, OFF_CTRL, OFF_FORCE, OFF_CMD, OFF_STATUS, OFF_PEND});
	sequence mask_wr;
		acc && pwrite_in && paddr_in == OFF_MASK;
	endsequence
	sequence dead_rd;
		acc && !pwrite_in && (hole || paddr_in == OFF_FORCE);
	endsequence
	a_pready_high: assert property (psel_in |-> pready_out)
		else $error("pready low in a transfer");
	a_err_decode: assert property (acc |-> pslverr_out == hole)
		else $error("pslverr does not match the address map");
	a_err_idle: assert property (!acc |-> !pslverr_out)
		else $error("pslverr outside access phase");
	a_read_dead: assert property (dead_rd |-> prdata_out == 32'h0)
		else $error("write-only or unmapped read returned data");
	a_mask_block: assert property (mask_wr |-> ##2 !int_take_out)
		else $error("interrupt taken right after a mask write");
	a_take_vector: assert property (int_take_out |-> vector_out inside {VEC_TABLE})
		else $error("vector outside the table");
	a_ack_halts: assert property (powerdown_ack_out |-> !run_out)
		else $error("running while acknowledging power-down");
	a_ack_quiet: assert property (powerdown_ack_out |-> !int_take_out)
		else $error("interrupt taken in power-down");
endmodule
`default_nettype wire

// file: tb/pin_model.sv
// External interrupt pin sources beside the controller.
// Assumes pins idle high through pull-ups and are driven low on request.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
	input wire logic clk_in,
	input wire logic [6:0] low_in,
	output logic [6:0] pins_n_out
);
	initial pins_n_out = 7'h7F;
	// Each request holds its pin for whole cycles, with gaps the bench keeps.
	always @(posedge clk_in) begin
		pins_n_out <= ~low_in;
	end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the interrupt and low-power controller.
// Assumes the package, pin model and checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import intc_pkg::*;
	logic clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic serial_alt_mode_in = 0, pready_out, pslverr_out, int_take_out, run_out;
	logic context_clear_out, powerdown_ack_out, er, ckout;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, status_in = 32'h0, prdata_out, status_restore_out, rd;
	logic [31:0] seed = 32'h2EF1432A;
	logic [6:0] low = 7'h00, pins_n;
	logic [5:0] internal_int_in = 6'h00;
	logic [13:0] vector_out, expq[$];
	int failures = 0, n_checks = 0, cyc = 0;
	int ps[6] = '{SRC_SEL, SRC_LVA, SRC_LVB, SRC_EDGE, SRC_SBRX, SRC_SBTX};
	always #5 clk_in = ~clk_in;
	pin_model PM (.clk_in, .low_in(low), .pins_n_out(pins_n));
	intc_lowpower #(.WAKE_XTAL(40), .WAKE_FAST(20)) DUT (.*, .cycle_clock_output_out(ckout),
		.ext_selectable_int_n_in(pins_n[0]), .ext_level_int_a_n_in(pins_n[1]),
		.ext_level_int_b_n_in(pins_n[2]), .ext_edge_int_n_in(pins_n[3]),
		.serial_alt_int_a_n_in(pins_n[4]), .serial_alt_int_b_n_in(pins_n[5]),
		.powerdown_request_pin_n_in(pins_n[6]));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 50);
		if (k >= 50) chk(pready_out, 1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic wait_q;
		int k;
		k = 0;
		while (expq.size() != 0 && k < 300) begin
			@(posedge clk_in);
			k++;
		end
		chk(expq.size(), 0);
		expq.delete();
	endtask
	// Every vector the controller hands out is matched against the oldest note.
	always @(posedge clk_in) begin
		cyc++;
		if (int_take_out === 1'b1) begin
			if (expq.size() == 0) chk({18'h0, vector_out}, 32'hFFFFFFFF);
			else chk({18'h0, vector_out}, {18'h0, expq.pop_front()});
		end
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	initial begin
		logic [11:0] m;
		logic c;
		int k;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		chk({run_out, powerdown_ack_out}, 2'b10);
		apb(1'b0, OFF_STATUS, 0);
		chk(rd[8], 1);
		wr(OFF_FORCE, 32'h0);
		apb(1'b0, OFF_FORCE, 0);
		chk(rd, 0);
		apb(1'b0, 8'h18, 0);
		chk(er, 1);
		$display("test registers done");
		wr(OFF_MASK, 32'hFFF);
		for (int i = 0; i < NSRC; i++) begin
			if (i == SRC_LVA || i == SRC_LVB) continue;
			seed = xs(seed);
			status_in <= seed;
			expq.push_back(VEC_TABLE[i]);
			if (i == SRC_TMR) begin
				internal_int_in <= 6'h20;
				@(posedge clk_in);
				internal_int_in <= 6'h00;
			end else wr(OFF_FORCE, 1 << i);
			wait_q();
			wr(OFF_CMD, 1 << CMD_RTI);
			repeat (3) @(posedge clk_in);
			chk(status_restore_out, seed);
		end
		$display("test vectors done");
		seed = xs(seed);
		m = seed[11:0] & 12'hFF2;
		wr(OFF_CMD, 1 << CMD_DIS);
		wr(OFF_FORCE, 32'hFF3);
		wr(OFF_MASK, {20'h0, m});
		repeat (10) @(posedge clk_in);
		for (int i = 0; i < NSRC; i++) begin
			if (i != SRC_PWD && !m[i]) continue;
			expq.push_back(VEC_TABLE[i]);
			wr(OFF_CMD, (i == SRC_PWD) ? (1 << CMD_ENA) : (1 << CMD_RTI));
			wait_q();
		end
		wr(OFF_CMD, 1 << CMD_RTI);
		wr(OFF_FORCE, 32'h0FFF0000);
		wr(OFF_MASK, 32'hFFF);
		$display("test priority done");
		for (int nest = 0; nest < 2; nest++) begin
			wr(OFF_CTRL, nest << CTRL_NEST);
			expq.push_back(VEC_TABLE[SRC_TMR]);
			wr(OFF_FORCE, 1 << SRC_TMR);
			wait_q();
			if (nest) expq.push_back(VEC_TABLE[SRC_SEL]);
			wr(OFF_FORCE, 1 << SRC_SEL);
			repeat (8) @(posedge clk_in);
			chk(expq.size(), 0);
			if (!nest) expq.push_back(VEC_TABLE[SRC_SEL]);
			wr(OFF_CMD, 1 << CMD_RTI);
			wait_q();
			wr(OFF_CMD, 1 << CMD_RTI);
		end
		$display("test nesting done");
		serial_alt_mode_in <= 1'b1;
		wr(OFF_CTRL, 32'h7);
		for (int p = 0; p < 6; p++) begin
			wr(OFF_CMD, 1 << CMD_DIS);
			low[p] <= 1'b1;
			repeat (4) @(posedge clk_in);
			if (p != 1 && p != 2) low[p] <= 1'b0;
			repeat (4) @(posedge clk_in);
			expq.push_back(VEC_TABLE[ps[p]]);
			wr(OFF_CMD, 1 << CMD_ENA);
			wait_q();
			low[p] <= 1'b0;
			wr(OFF_CMD, 1 << CMD_RTI);
			repeat (8) @(posedge clk_in);
		end
		$display("test pins done");
		for (int d = 0; d < 5; d++) begin
			wr(OFF_CMD, (1 << CMD_IDLE) | (d << CMD_DIV_LO));
			repeat (4) @(posedge clk_in);
			chk(run_out, 0);
			c = ckout;
			do @(posedge clk_in); while (ckout === c);
			c = ckout;
			k = 0;
			do begin
				@(posedge clk_in);
				k++;
			end while (ckout === c && k < 300);
			chk(k, d ? (8 << d) : 1);
			expq.push_back(VEC_TABLE[SRC_DMA]);
			wr(OFF_FORCE, 1 << SRC_DMA);
			wait_q();
			wr(OFF_CMD, 1 << CMD_RTI);
			chk(run_out, 1);
		end
		$display("test idle done");
		for (int x = 0; x < 2; x++) begin
			wr(OFF_CTRL, x ? 32'h30 : 32'h0);
			expq.push_back(VEC_TABLE[SRC_PWD]);
			low[6] <= 1'b1;
			repeat (3) @(posedge clk_in);
			low[6] <= 1'b0;
			wait_q();
			wr(OFF_CMD, 1 << CMD_DIS);
			wr(OFF_CMD, 1 << CMD_PWD_FORCE);
			repeat (4) @(posedge clk_in);
			chk({powerdown_ack_out, run_out}, 2'b10);
			low[6] <= 1'b1;
			k = 0;
			c = 1'b0;
			do begin
				@(posedge clk_in);
				k++;
				c |= (context_clear_out === 1'b1);
			end while (run_out !== 1'b1 && k < 200);
			chk(k >= (x ? 40 : 20) && k <= (x ? 40 : 20) + 12, 1);
			low[6] <= 1'b0;
			repeat (4) begin
				@(posedge clk_in);
				c |= (context_clear_out === 1'b1);
			end
			chk(c, x);
			wr(OFF_FORCE, 32'h0FFF0000);
			wr(OFF_CMD, 1 << CMD_ENA);
			if (!x) wr(OFF_CMD, 1 << CMD_RTI);
		end
		$display("test power-down done");
		test_done();
	end
endmodule
bind intc_lowpower intc_assertions chk (.*);
`default_nettype wire
